// file: wds_pkg.sv
// Purpose: constants, types and timing for the reset and watchdog supervisor
// Assumes: 40 MHz system clock, APB register access, write-only serial frames
// Notes: all times held in their own unit, cycle counts derived here
package wds_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_NS = 25;
	localparam int T_MS_NS = 1000000;
	localparam int T_RF_NS = 10000;
	localparam int T_LW_MS = 200;
	localparam int T_RD_MS = 10;
	localparam int TICK_CYC = T_MS_NS / CLK_NS;
	localparam int RF_CYC = (T_RF_NS + CLK_NS - 1) / CLK_NS;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] MODE_OFF = 8'h00;
	localparam logic [7:0] CFG_OFF = 8'h04;
	localparam logic [7:0] STAT_OFF = 8'h08;
	localparam logic [7:0] WDC_OFF = 8'h0c;
	localparam logic [6:0] WD_SPI_ADDR = 7'h15;
	localparam int FRAME_BITS = 16;

	// config register fields
	localparam int CFG_SRR = 0;
	localparam int CFG_FS = 1;
	localparam int CFG_FC = 2;
	localparam logic [3:0] CFG_RST = 4'h1;

	// watchdog control byte fields
	localparam int WDC_PAR = 7;
	localparam int WDC_TYPE = 6;
	localparam int WDC_RSV = 3;
	localparam int WDC_PER = 0;
	localparam logic [7:0] WDC_RST = 8'h81;

	// status register fields
	localparam int ST_MODE = 0;
	localparam int ST_RO = 3;
	localparam int ST_FAIL = 4;
	localparam int ST_SPIF = 6;

	// mode field command values, fail count setting and limits
	localparam logic [1:0] CMD_NORMAL = 2'h0;
	localparam logic [1:0] CMD_STOP = 2'h1;
	localparam logic [1:0] CMD_SLEEP = 2'h2;
	localparam logic [1:0] CMD_SOFT = 2'h3;
	localparam logic [1:0] FC_CFG2 = 2'h1;
	localparam logic [1:0] FAIL_MAX_CFG2 = 2'h1;
	localparam logic [1:0] FAIL_MAX = 2'h2;

	typedef enum logic [2:0] {
		MD_INIT = 3'h0,
		MD_NORMAL = 3'h1,
		MD_STOP = 3'h2,
		MD_SLEEP = 3'h3,
		MD_RESTART = 3'h4,
		MD_FAILSAFE = 3'h5
	} wds_mode_t;

	typedef struct packed {
		logic sck;
		logic mosi;
		logic chip_select_active_low;
	} wds_spi_t;

	typedef struct packed {
		logic [4:0] sy1;
		logic [4:0] sy2;
		logic [4:0] sy3;
		logic [15:0] div;
		logic [15:0] sh;
		logic [4:0] bits;
		logic [9:0] filt;
		logic uv_f;
		logic ro_low;
		logic [7:0] rd_ms;
		logic [10:0] wd_ms;
		logic long_win;
		logic [7:0] wdc;
		logic [3:0] cfg;
		logic [1:0] fail;
		logic wd_caused;
		logic spi_fail;
		wds_mode_t mode;
		logic [31:0] prdata;
		logic pslverr;
	} wds_state_t;

	// setting 1..7 in milliseconds, setting 0 read as setting 1
	function automatic logic [10:0] wd_period_ms(input logic [2:0] code);
		case (code)
			3'h2: wd_period_ms = 11'd20;
			3'h3: wd_period_ms = 11'd50;
			3'h4: wd_period_ms = 11'd100;
			3'h5: wd_period_ms = 11'd200;
			3'h6: wd_period_ms = 11'd500;
			3'h7: wd_period_ms = 11'd1000;
			default: wd_period_ms = 11'd10;
		endcase
	endfunction

endpackage

// file: wds_top.sv
// Purpose: reset output and watchdog supervisor with APB registers
// Assumes: serial pins and supply flags are asynchronous to clock_i
// Notes: watchdog time base is a 1 ms tick enable from a divider
//
// Contract
// - reset event pulls reset low after filter, holds while present plus delay
// - reset starts low at power-up, released after supply good plus delay
// - mode write 11 in normal or stop returns to init, defaults restored
// - soft reset command outside normal or stop is ignored
// - config bit chooses whether soft reset pulses the reset output
// - type select bit picks time-out (default) or window watchdog
// - watchdog type and period change only in normal mode, or back to defaults on soft reset from normal or stop
// - watchdog off in sleep and restart, long window after release and normal entry
// - valid serial watchdog write is a trigger, applied at chip select rise
// - new watchdog setting restarts the timer with that setting
// - long open window lasts 200 ms, any valid trigger accepted
// - period settings 1 to 7 map to 10 through 1000 ms
// - watchdog failure resets, enters restart (normal after release) or fail-safe
// - development mode disables watchdog failures entirely
// - failures increment a counter saturating at 01 or 10 by config
// - fail counter clears on good trigger, sleep, fail-safe not from watchdog
// - time-out mode: trigger restarts period, expiry is a failure
// - window mode: closed window 60 percent then open window centred on period
// - window mode: closed-window trigger or expiry is a failure
// - watchdog byte bits 15 to 8 carry even parity, checked here
// - parity error discards write, sets serial error, reserved bit counted
`timescale 1ns/1ps
module wds_top #(
	parameter int TICK_CYC = wds_pkg::TICK_CYC,
	parameter int LW_MS = wds_pkg::T_LW_MS,
	parameter int RD_MS = wds_pkg::T_RD_MS,
	parameter int RF_CYC = wds_pkg::RF_CYC
) (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire wds_pkg::wds_spi_t spi_i,
	input wire logic supply_uv_i,
	input wire logic dev_mode_i,
	output logic reset_out_n_o
);

	// ****************************************
	// state and decode
	// ****************************************
	wds_pkg::wds_state_t s;
	wds_pkg::wds_state_t n;
	logic sck_rise;
	logic cs_rise;
	logic tick;
	logic uv;
	logic dev;
	logic wd_on;
	logic wd_write;
	logic par_ok;
	logic closed;
	logic expire;
	logic watchdog_fail_count;
	logic trig_ok;
	logic apb_wr;
	logic apb_rd;
	logic [10:0] per;
	logic [10:0] lim;
	logic [15:0] scaled;
	logic [1:0] fmax;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == wds_pkg::MODE_OFF) || (a == wds_pkg::CFG_OFF) ||
			(a == wds_pkg::STAT_OFF) || (a == wds_pkg::WDC_OFF);
	endfunction

	assign pready_o = 1'b1;
	assign prdata_o = s.prdata;
	assign pslverr_o = s.pslverr;
	assign reset_out_n_o = ~s.ro_low;

	always_comb begin
		n = s;
		// ****************************************
		// synchronisers, only stage two onward is read
		// ****************************************
		n.sy1 = {spi_i.sck, spi_i.mosi, spi_i.chip_select_active_low, supply_uv_i, dev_mode_i};
		n.sy2 = s.sy1;
		n.sy3 = s.sy2;
		sck_rise = s.sy2[4] & ~s.sy3[4];
		cs_rise = s.sy2[2] & ~s.sy3[2];
		uv = s.sy2[1];
		dev = s.sy2[0];

		// ****************************************
		// millisecond tick
		// ****************************************
		tick = 1'b0;
		if (s.div == 16'(TICK_CYC - 1)) begin
			n.div = 16'h0000;
			tick = 1'b1;
		end else begin
			n.div = s.div + 16'h0001;
		end

		// ****************************************
		// serial frame receive
		// ****************************************
		if (s.sy2[2]) begin
			n.bits = 5'h00;
		end else if (sck_rise) begin
			n.sh = {s.sh[14:0], s.sy2[3]};
			if (s.bits != 5'h1f) begin
				n.bits = s.bits + 5'h01;
			end
		end
		// only a full 16-bit write to the watchdog address counts
		wd_write = cs_rise && (s.bits == 5'(wds_pkg::FRAME_BITS)) && s.sh[7] &&
			(s.sh[6:0] == wds_pkg::WD_SPI_ADDR);
		par_ok = ~^s.sh[15:8];

		// ****************************************
		// watchdog timing
		// ****************************************
		per = wds_pkg::wd_period_ms(s.wdc[wds_pkg::WDC_PER+:3]);
		scaled = 16'h0000;
		if (s.long_win) begin
			lim = 11'(LW_MS);
		end else if (s.wdc[wds_pkg::WDC_TYPE]) begin
			// open window runs 0.6 to 1.4 of the period
			scaled = 16'({5'h00, per} * 16'd14 / 16'd10);
			lim = scaled[10:0];
		end else begin
			lim = per;
		end
		closed = ~s.long_win && s.wdc[wds_pkg::WDC_TYPE] &&
			({5'h00, s.wd_ms} < 16'({5'h00, per} * 16'd6 / 16'd10));
		wd_on = ~dev && ((s.mode == wds_pkg::MD_INIT && ~s.ro_low) ||
			s.mode == wds_pkg::MD_NORMAL || s.mode == wds_pkg::MD_STOP);
		// fail on the tick that completes the period, not one tick later
		expire = tick && (s.wd_ms >= lim - 11'h001);
		watchdog_fail_count = wd_on && (expire || (wd_write && par_ok && closed));
		trig_ok = wd_on && wd_write && par_ok && ~closed;
		fmax = (s.cfg[wds_pkg::CFG_FC+:2] == wds_pkg::FC_CFG2) ?
			wds_pkg::FAIL_MAX_CFG2 : wds_pkg::FAIL_MAX;

		if (~wd_on) begin
			n.wd_ms = 11'h000;
		end else if (tick && s.wd_ms != 11'h7ff) begin
			n.wd_ms = s.wd_ms + 11'h001;
		end

		if (wd_write && ~par_ok) begin
			n.spi_fail = 1'b0;
		end
		if (trig_ok) begin
			n.wd_ms = 11'h000;
			n.long_win = 1'b0;
			n.fail = 2'h0;
			if (s.mode == wds_pkg::MD_NORMAL) begin
				n.wdc = s.sh[15:8];
			end
		end

		// ****************************************
		// reset output
		// ****************************************
		if (uv) begin
			if (s.filt == 10'(RF_CYC)) begin
				n.uv_f = 1'b1;
			end else begin
				n.filt = s.filt + 10'h001;
			end
		end else begin
			n.filt = 10'h000;
			n.uv_f = 1'b0;
		end

		if (s.uv_f) begin
			n.ro_low = 1'b1;
			n.rd_ms = 8'h00;
		end else if (s.ro_low && tick) begin
			if (s.rd_ms == 8'(RD_MS - 1)) begin
				n.ro_low = 1'b0;
				n.rd_ms = 8'h00;
				n.wd_ms = 11'h000;
				n.long_win = 1'b1;
				if (s.mode == wds_pkg::MD_RESTART) begin
					n.mode = wds_pkg::MD_NORMAL;
				end
			end else begin
				n.rd_ms = s.rd_ms + 8'h01;
			end
		end

		if (watchdog_fail_count) begin
			n.ro_low = 1'b1;
			n.rd_ms = 8'h00;
			n.wd_ms = 11'h000;
			n.wd_caused = 1'b1;
			n.mode = s.cfg[wds_pkg::CFG_FS] ? wds_pkg::MD_FAILSAFE : wds_pkg::MD_RESTART;
			if (s.fail < fmax) begin
				n.fail = s.fail + 2'h1;
			end
		end

		// ****************************************
		// APB slave, zero wait states
		// ****************************************
		apb_wr = psel_i && penable_i && pwrite_i;
		apb_rd = psel_i && ~penable_i && ~pwrite_i;
		if (psel_i && ~penable_i) begin
			n.pslverr = ~mapped(paddr_i);
			n.prdata = 32'h00000000;
		end
		if (apb_rd) begin
			case (paddr_i)
				wds_pkg::MODE_OFF: n.prdata[2:0] = s.mode;
				wds_pkg::CFG_OFF: n.prdata[3:0] = s.cfg;
				wds_pkg::STAT_OFF: begin
					n.prdata[wds_pkg::ST_MODE+:3] = s.mode;
					n.prdata[wds_pkg::ST_RO] = ~s.ro_low;
					n.prdata[wds_pkg::ST_FAIL+:2] = s.fail;
					n.prdata[wds_pkg::ST_SPIF] = s.spi_fail;
				end
				wds_pkg::WDC_OFF: begin
					// reserved bit reads zero yet still counts in parity
					n.prdata[7:0] = s.wdc;
					n.prdata[wds_pkg::WDC_RSV] = 1'b0;
				end
				default: n.prdata = 32'h00000000;
			endcase
		end

		if (apb_wr && paddr_i == wds_pkg::STAT_OFF && pwdata_i[wds_pkg::ST_SPIF]) begin
			n.spi_fail = 1'b0;
		end
		if (apb_wr && paddr_i == wds_pkg::CFG_OFF && s.mode == wds_pkg::MD_NORMAL) begin
			n.cfg = pwdata_i[3:0];
		end
		if (apb_wr && paddr_i == wds_pkg::MODE_OFF && ~watchdog_fail_count) begin
			case (pwdata_i[1:0])
				wds_pkg::CMD_NORMAL: begin
					if (s.mode != wds_pkg::MD_NORMAL && s.mode != wds_pkg::MD_RESTART) begin
						n.mode = wds_pkg::MD_NORMAL;
						n.long_win = 1'b1;
						n.wd_ms = 11'h000;
						n.wd_caused = 1'b0;
					end
				end
				wds_pkg::CMD_STOP: begin
					if (s.mode == wds_pkg::MD_NORMAL) begin
						n.mode = wds_pkg::MD_STOP;
					end
				end
				wds_pkg::CMD_SLEEP: begin
					if (s.mode == wds_pkg::MD_NORMAL) begin
						n.mode = wds_pkg::MD_SLEEP;
					end
				end
				wds_pkg::CMD_SOFT: begin
					// other modes: command dropped, nothing changes
					if (s.mode == wds_pkg::MD_NORMAL || s.mode == wds_pkg::MD_STOP) begin
						n.mode = wds_pkg::MD_INIT;
						n.cfg = wds_pkg::CFG_RST;
						n.wdc = wds_pkg::WDC_RST;
						n.fail = 2'h0;
						n.spi_fail = 1'b0;
						n.wd_caused = 1'b0;
						n.long_win = 1'b1;
						n.wd_ms = 11'h000;
						if (s.cfg[wds_pkg::CFG_SRR]) begin
							n.ro_low = 1'b1;
							n.rd_ms = 8'h00;
						end
					end
				end
				default: n.mode = s.mode;
			endcase
		end

		// error set after any clear so a coincident event survives
		if (wd_write && ~par_ok) begin
			n.spi_fail = 1'b1;
		end
		if (n.mode == wds_pkg::MD_SLEEP ||
			(n.mode == wds_pkg::MD_FAILSAFE && ~n.wd_caused)) begin
			n.fail = 2'h0;
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s <= '0;
			s.sy1 <= 5'h04;
			s.sy2 <= 5'h04;
			s.sy3 <= 5'h04;
			s.ro_low <= 1'b1;
			s.long_win <= 1'b1;
			s.wdc <= wds_pkg::WDC_RST;
			s.cfg <= wds_pkg::CFG_RST;
			s.mode <= wds_pkg::MD_INIT;
		end else begin
			s <= n;
		end
	end

endmodule // wds_top

// file: wds_top_monitor.sv
// Purpose: port checks of the reset and watchdog supervisor
// Assumes: bound into wds_top, one clock domain
// Notes: reset length judged with one tick of slack
`timescale 1ns/1ps
module wds_top_monitor #(
	parameter int TICK_CYC = 40,
	parameter int LW_MS = 200,
	parameter int RD_MS = 10,
	parameter int RF_CYC = 4
) (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire wds_pkg::wds_spi_t spi_i,
	input wire logic supply_uv_i,
	input wire logic dev_mode_i,
	input wire logic reset_out_n_o
);
	// ****
	// low time counter
	// ****
	logic [31:0] low_cnt;
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i)
			low_cnt <= '0;
		else if (reset_out_n_o)
			low_cnt <= '0;
		else
			low_cnt <= low_cnt + 32'h1;
	end
	// ****
	// properties
	// ****
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	a_start_low: assert property (
		$rose(rst_b_i) |-> !reset_out_n_o [*8]) else $error("reset released too soon");
	a_uv_pulls: assert property (
		supply_uv_i [*8] |-> ##3 !reset_out_n_o) else $error("supply low not seen");
	a_uv_holds: assert property (
		!reset_out_n_o && supply_uv_i |=> !reset_out_n_o) else $error("reset left early");
	a_uv_delay: assert property (
		$fell(supply_uv_i) && !reset_out_n_o |=> !reset_out_n_o [*8])
		else $error("no delay after supply good");
	a_low_length: assert property (
		$rose(reset_out_n_o) |-> low_cnt >= (RD_MS - 1) * TICK_CYC)
		else $error("reset pulse too short");
	a_unmapped_err: assert property (
		psel_i && !penable_i && paddr_i > 8'h0c |=> pslverr_o) else $error("no slave error");
	a_mapped_ok: assert property (
		psel_i && !penable_i && paddr_i <= 8'h0c && paddr_i[1:0] == 2'h0 |=> !pslverr_o)
		else $error("error on mapped address");
	a_unmapped_zero: assert property (
		psel_i && !penable_i && !pwrite_i && paddr_i > 8'h0c |=> prdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_rd_hold: assert property (
		psel_i && penable_i |=> $stable(prdata_o) && $stable(pslverr_o))
		else $error("read data moved");
endmodule // wds_top_monitor

bind wds_top wds_top_monitor #(.TICK_CYC(TICK_CYC), .LW_MS(LW_MS), .RD_MS(RD_MS),
	.RF_CYC(RF_CYC)) u_mon (.clock_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
	.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .spi_i, .supply_uv_i, .dev_mode_i,
	.reset_out_n_o);

// file: wds_host.sv
// Purpose: host model sending watchdog frames
// Assumes: sck period 9 clocks, msb first
// Notes: sck stands still and mosi toggles between frames
`timescale 1ns/1ps
module wds_host (
	input wire logic clock_i,
	output wds_pkg::wds_spi_t spi_o
);
	initial spi_o = 3'h1;
	// idle data line never holds the last bit
	always @(posedge clock_i) begin
		if (spi_o.chip_select_active_low)
			spi_o.mosi <= ~spi_o.mosi;
	end
	// ok low inverts parity on purpose
	task automatic send(input logic [6:0] d, input logic ok);
		logic [15:0] f;
		f = {^d ^ !ok, d, 1'b1, wds_pkg::WD_SPI_ADDR};
		@(posedge clock_i);
		spi_o.chip_select_active_low <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			@(posedge clock_i);
			spi_o.mosi <= f[i];
			repeat (4) @(posedge clock_i);
			spi_o.sck <= 1'b1;
			repeat (4) @(posedge clock_i);
			spi_o.sck <= 1'b0;
		end
		repeat (4) @(posedge clock_i);
		spi_o.chip_select_active_low <= 1'b1;
		repeat (8) @(posedge clock_i);
	endtask
endmodule // wds_host

// file: tb_wds_top.sv
// Purpose: self-checking bench for the supervisor
// Assumes: ms tick shortened to 40 clocks
// Notes: window timings rely on fixed frame length
`timescale 1ns/1ps
module tb_wds_top;
	logic clock_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h0;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	wds_pkg::wds_spi_t spi;
	logic supply_uv_i = 1'b0;
	logic dev_mode_i = 1'b0;
	logic reset_out_n_o;
	logic [31:0] rd;
	logic er;
	int error_cnt = 0;
	int num_checks = 0;
	always #12.5 clock_i = ~clock_i;
	wds_top #(.TICK_CYC(40), .LW_MS(200), .RD_MS(10), .RF_CYC(4)) DUT (.clock_i, .rst_b_i,
		.psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
		.pslverr_o, .spi_i(spi), .supply_uv_i, .dev_mode_i, .reset_out_n_o);
	wds_host u_host (.clock_i, .spi_o(spi));
	// ****
	// tasks
	// ****
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		do @(posedge clock_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// cycles until reset output reaches v, judged against a range
	task automatic wt(input logic v, input int lo, input int hi);
		int n;
		n = 0;
		@(negedge clock_i);
		while (reset_out_n_o !== v && n <= hi) begin
			@(negedge clock_i);
			n++;
		end
		chk(32'(n >= lo && n <= hi), 32'h1);
	endtask
	task automatic wrap_up;
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ****
	// tests
	// ****
	initial begin
		repeat (60000) @(posedge clock_i);
		error_cnt++;
		wrap_up();
	end
	initial begin
		repeat (4) @(posedge clock_i);
		rst_b_i <= 1'b1;
		chk(reset_out_n_o, 32'h0);
		rdc(8'h08, 32'h0);
		wt(1'b1, 340, 460);
		rdc(8'h04, 32'h1);
		rdc(8'h0c, 32'h81);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0);
		chk(er, 32'h1);
		u_host.send(7'h41, 1'b1);
		apb(1'b1, 8'h00, 32'h0);
		rdc(8'h08, 32'h09);
		rdc(8'h0c, 32'h81);
		u_host.send(7'h41, 1'b1);
		rdc(8'h0c, 32'h41);
		u_host.send(7'h49, 1'b0);
		rdc(8'h08, 32'h49);
		rdc(8'h0c, 32'h41);
		apb(1'b1, 8'h08, 32'h40);
		// lands near 0.8 of the period, inside the open window
		u_host.send(7'h41, 1'b1);
		rdc(8'h08, 32'h09);
		u_host.send(7'h41, 1'b1);
		wt(1'b0, 0, 20);
		rdc(8'h08, 32'h14);
		wt(1'b1, 340, 440);
		rdc(8'h08, 32'h19);
		wt(1'b0, 7880, 8060);
		rdc(8'h08, 32'h24);
		wt(1'b1, 340, 440);
		wt(1'b0, 7880, 8060);
		rdc(8'h08, 32'h24);
		wt(1'b1, 340, 440);
		u_host.send(7'h41, 1'b1);
		rdc(8'h08, 32'h09);
		repeat (200) @(posedge clock_i);
		u_host.send(7'h02, 1'b1);
		wt(1'b0, 740, 820);
		rdc(8'h08, 32'h14);
		rdc(8'h0c, 32'h82);
		wt(1'b1, 340, 440);
		dev_mode_i <= 1'b1;
		repeat (8500) @(negedge clock_i);
		chk(reset_out_n_o, 32'h1);
		apb(1'b1, 8'h00, 32'h3);
		wt(1'b0, 0, 10);
		rdc(8'h0c, 32'h81);
		wt(1'b1, 340, 440);
		dev_mode_i <= 1'b0;
		apb(1'b1, 8'h00, 32'h3);
		rdc(8'h08, 32'h08);
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h00, 32'h3);
		repeat (20) @(negedge clock_i);
		chk(reset_out_n_o, 32'h1);
		rdc(8'h04, 32'h1);
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h00, 32'h2);
		apb(1'b1, 8'h00, 32'h3);
		rdc(8'h08, 32'h0b);
		repeat (8500) @(negedge clock_i);
		chk(reset_out_n_o, 32'h1);
		@(posedge clock_i);
		supply_uv_i <= 1'b1;
		wt(1'b0, 4, 14);
		repeat (100) @(negedge clock_i);
		chk(reset_out_n_o, 32'h0);
		@(posedge clock_i);
		supply_uv_i <= 1'b0;
		wt(1'b1, 350, 450);
		wrap_up();
	end
endmodule // tb_wds_top
